// >>> on_off_state_controller.sv
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "onoff_cfg.svh"
module on_off_state_controller
#(
  parameter int HOLD_GF_CYC = `ONOFF_HOLD_GF_US * `ONOFF_CLK_MHZ,
  parameter int HOLD_WAIT_CYC = `ONOFF_HOLD_WAIT_US * `ONOFF_CLK_MHZ
)
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic supply_ok_in,
  input wire logic config_settled_in,
  input wire logic io_supply_valid_in,
  input wire logic bias_ok_flag_in,
  input wire logic debounced_key_flag_in,
  input wire logic power_hold_input_in,
  input wire logic overtemp_lockout_in,
  input wire logic manual_reset_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  output logic [7:0] rd_data_out,
  output logic internal_reset_n_out,
  output logic bus_enable_out,
  output logic main_bias_en_out,
  output logic bias_low_power_out,
  output logic [2:0] regulator_en_out,
  output onoff_pkg::onoff_state_t state_out
);

  import onoff_pkg::*;

  onoff_state_t state_r;
  onoff_state_t state_nxt;
  logic bias_enable_bit_r;
  logic [2:0] reg_en_r;
  logic wakeup_flag_r;
  logic key_flag_r;
  logic [19:0] hold_tmr_r;
  logic filtered_power_hold;
  logic [2:0] power_sequencer_slots;
  logic up_done, down_done;
  logic ctrl_wr, bias_wr_one, bias_wr_zero, srst_cold, srst_off;
  logic hold_expired, up_start, down_start;

  function automatic logic bias_on(input onoff_state_t st);
    bias_on = (st != ST_NO_POWER) && (st != ST_INT_RESET) && (st != ST_STANDBY);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // hold glitch filter
  hold_glitch_filter #(.GF_CYC(HOLD_GF_CYC)) u_hold_filter
  (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .raw_in(power_hold_input_in),
    .filt_out(filtered_power_hold)
  );

  assign up_start = (state_r == ST_WAKE_BIAS) && (state_nxt == ST_PWR_UP);
  assign down_start = (state_r != ST_PWR_DOWN) && (state_nxt == ST_PWR_DOWN);

  slot_sequencer u_seq
  (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .clear_in(!supply_ok_in),
    .up_start_in(up_start),
    .down_start_in(down_start),
    .slot_en_out(power_sequencer_slots),
    .up_done_out(up_done),
    .down_done_out(down_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // register writes
  assign ctrl_wr = wr_en_in && (addr_in == `ONOFF_CTRL_ADDR);
  assign bias_wr_one = ctrl_wr && wr_data_in[`ONOFF_CTRL_BIAS_BIT];
  assign bias_wr_zero = ctrl_wr && !wr_data_in[`ONOFF_CTRL_BIAS_BIT];
  assign srst_cold = ctrl_wr && (wr_data_in[`ONOFF_CTRL_SRST_HI:`ONOFF_CTRL_SRST_LO] == `ONOFF_SRST_COLD);
  assign srst_off = ctrl_wr && (wr_data_in[`ONOFF_CTRL_SRST_HI:`ONOFF_CTRL_SRST_LO] == `ONOFF_SRST_OFF);

  // registers lose their content with the supply
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      bias_enable_bit_r <= `ONOFF_BIAS_RST;
      reg_en_r <= `ONOFF_REGEN_RST;
    end
    else if (state_r == ST_NO_POWER)
    begin
      bias_enable_bit_r <= `ONOFF_BIAS_RST;
      reg_en_r <= `ONOFF_REGEN_RST;
    end
    else if (ctrl_wr)
    begin
      bias_enable_bit_r <= wr_data_in[`ONOFF_CTRL_BIAS_BIT];
    end
    else if (wr_en_in && addr_in == `ONOFF_REGEN_ADDR)
    begin
      reg_en_r <= wr_data_in[2:0];
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rd_data_out <= 8'h00;
    end
    else if (rd_en_in && addr_in == `ONOFF_CTRL_ADDR)
    begin
      rd_data_out <= {7'h00, bias_enable_bit_r};
    end
    else if (rd_en_in && addr_in == `ONOFF_REGEN_ADDR)
    begin
      rd_data_out <= {5'h00, reg_en_r};
    end
    else if (rd_en_in && addr_in == `ONOFF_STATUS_ADDR)
    begin
      rd_data_out <= {key_flag_r, wakeup_flag_r, bias_ok_flag_in, filtered_power_hold, state_r};
    end
    else
    begin
      rd_data_out <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // wake flags, supply loss clears both, else a set beats a same-cycle clear
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      wakeup_flag_r <= 1'b0;
      key_flag_r <= 1'b0;
    end
    else if (!supply_ok_in)
    begin
      wakeup_flag_r <= 1'b0;
      key_flag_r <= 1'b0;
    end
    else
    begin
      // cold reset from the on state restarts after power-down
      if (srst_cold && (state_r == ST_STANDBY || state_r == ST_HW_ON))
      begin
        wakeup_flag_r <= 1'b1;
      end
      else if (up_start || state_nxt == ST_WAKE_BIAS)
      begin
        wakeup_flag_r <= 1'b0;
      end
      if (debounced_key_flag_in && state_r == ST_STANDBY)
      begin
        key_flag_r <= 1'b1;
      end
      else if (state_nxt == ST_WAKE_BIAS)
      begin
        key_flag_r <= 1'b0;
      end
    end
  end

  // hold wait timer restarts on every entry
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      hold_tmr_r <= 20'h00000;
    end
    else if (state_r != ST_HOLD_CHECK)
    begin
      hold_tmr_r <= 20'h00000;
    end
    else if (!hold_expired)
    begin
      hold_tmr_r <= hold_tmr_r + 20'h00001;
    end
  end

  assign hold_expired = (hold_tmr_r == 20'(HOLD_WAIT_CYC));

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_NO_POWER:
        if (supply_ok_in) state_nxt = ST_INT_RESET;
      ST_INT_RESET:
        if (config_settled_in) state_nxt = ST_STANDBY;
      // wake takes priority over a bias write
      ST_STANDBY:
        if (key_flag_r || wakeup_flag_r) state_nxt = ST_WAKE_BIAS;
        else if (bias_wr_one) state_nxt = ST_SW_ON;
      ST_SW_ON:
        if (bias_wr_zero) state_nxt = ST_STANDBY;
      ST_WAKE_BIAS:
        if (bias_ok_flag_in) state_nxt = ST_PWR_UP;
      ST_PWR_UP:
        if (up_done) state_nxt = ST_HOLD_CHECK;
      ST_HOLD_CHECK:
        if (filtered_power_hold) state_nxt = ST_HW_ON;
        else if (hold_expired) state_nxt = ST_PWR_DOWN;
      ST_HW_ON:
        if (!filtered_power_hold || overtemp_lockout_in || srst_cold || srst_off || manual_reset_in)
          state_nxt = ST_PWR_DOWN;
      ST_PWR_DOWN:
        if (down_done) state_nxt = ST_STANDBY;
      default:
        state_nxt = ST_NO_POWER;
    endcase
    if (!supply_ok_in)
    begin
      state_nxt = ST_NO_POWER;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs follow the next state so they line up with state_r
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      state_r <= ST_NO_POWER;
      state_out <= ST_NO_POWER;
      internal_reset_n_out <= 1'b0;
      bus_enable_out <= 1'b0;
      main_bias_en_out <= 1'b0;
      bias_low_power_out <= 1'b0;
      regulator_en_out <= 3'h0;
    end
    else
    begin
      state_r <= state_nxt;
      state_out <= state_nxt;
      internal_reset_n_out <= (state_nxt != ST_NO_POWER) && (state_nxt != ST_INT_RESET);
      // bus alive past no-power and internal reset while io supply valid
      bus_enable_out <= (state_nxt != ST_NO_POWER) && (state_nxt != ST_INT_RESET) && io_supply_valid_in;
      main_bias_en_out <= bias_on(state_nxt);
      // low-power bias in the on state
      bias_low_power_out <= (state_nxt == ST_HW_ON);
      // host owns the outputs in software-on
      if (state_nxt == ST_SW_ON)
      begin
        regulator_en_out <= reg_en_r;
      end
      else
      begin
        regulator_en_out <= power_sequencer_slots;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);

  a_supply_loss_state: assert property (!supply_ok_in |=> state_r == ST_NO_POWER)
    else $error("supply loss did not force no-power");
  a_settle_to_standby: assert property (state_r == ST_INT_RESET && config_settled_in && supply_ok_in
    |=> state_r == ST_STANDBY)
    else $error("settled config did not reach standby");
  a_standby_bias_off: assert property (state_r == ST_STANDBY |-> !main_bias_en_out && regulator_en_out == 3'h0)
    else $error("bias or outputs on in standby");
  a_bias_write_on: assert property (state_r == ST_STANDBY && bias_wr_one && !key_flag_r && !wakeup_flag_r
    && supply_ok_in |=> state_r == ST_SW_ON && main_bias_en_out)
    else $error("bias write did not enter software-on");
  a_bias_write_off: assert property (state_r == ST_SW_ON && bias_wr_zero && supply_ok_in
    |=> state_r == ST_STANDBY && !main_bias_en_out)
    else $error("bias clear did not return to standby");
  a_sw_outputs_follow: assert property (state_r == ST_SW_ON |-> regulator_en_out == $past(reg_en_r))
    else $error("software-on outputs not from host register");
  a_wait_bias_ok: assert property (state_r == ST_WAKE_BIAS && !bias_ok_flag_in |=> state_r != ST_PWR_UP)
    else $error("power-up started without bias ok");
  a_hold_timer_zero: assert property ($rose(state_r == ST_HOLD_CHECK) |-> hold_tmr_r == 20'h00000)
    else $error("hold timer not zero on entry");
  a_hold_timeout_down: assert property (state_r == ST_HOLD_CHECK && hold_expired && !filtered_power_hold
    && supply_ok_in |=> state_r == ST_PWR_DOWN)
    else $error("hold timeout did not power down");
  a_hold_enter_on: assert property (state_r == ST_HOLD_CHECK && filtered_power_hold && supply_ok_in
    |=> state_r == ST_HW_ON)
    else $error("hold high did not enter on state");
  a_on_state_outputs: assert property (state_r == ST_HW_ON |-> regulator_en_out == 3'h7
    && main_bias_en_out && bias_low_power_out)
    else $error("on state outputs wrong");
  a_on_state_exit: assert property (state_r == ST_HW_ON && supply_ok_in && (!filtered_power_hold
    || overtemp_lockout_in || manual_reset_in || srst_off || srst_cold) |=> state_r == ST_PWR_DOWN)
    else $error("power-down cause ignored");
  a_raw_hold_ignored: assert property ($rose(power_hold_input_in) |=> !$rose(filtered_power_hold))
    else $error("hold passed without filtering");
  a_down_to_standby: assert property (state_r == ST_PWR_DOWN && down_done && supply_ok_in
    |=> state_r == ST_STANDBY)
    else $error("finished power-down did not reach standby");

  c_key_wake: cover property (state_r == ST_STANDBY && key_flag_r ##1 state_r == ST_WAKE_BIAS);
  c_reach_on: cover property (state_r == ST_HOLD_CHECK ##1 state_r == ST_HW_ON);
  c_sw_on: cover property (state_r == ST_SW_ON);
  c_hold_timeout: cover property (state_r == ST_HOLD_CHECK && hold_expired);

endmodule

// >>> onoff_cfg.svh
`ifndef ONOFF_CFG_SVH
`define ONOFF_CFG_SVH

// register byte addresses
`define ONOFF_CTRL_ADDR 8'h00
`define ONOFF_REGEN_ADDR 8'h04
`define ONOFF_STATUS_ADDR 8'h08

// control register fields
`define ONOFF_CTRL_BIAS_BIT 0
`define ONOFF_CTRL_SRST_LO 1
`define ONOFF_CTRL_SRST_HI 2

// soft reset field codes
`define ONOFF_SRST_COLD 2'h1
`define ONOFF_SRST_OFF 2'h2

// reset values
`define ONOFF_BIAS_RST 1'h0
`define ONOFF_REGEN_RST 3'h0

// timing
`define ONOFF_CLK_MHZ 125
`define ONOFF_HOLD_GF_US 100
`define ONOFF_HOLD_WAIT_US 1000
`define ONOFF_SLOT_STEP_CYC 16'h0010

`endif

// >>> onoff_pkg.sv
package onoff_pkg;

  // gray steps along the power-up path
  typedef enum logic [3:0]
  {
    ST_NO_POWER = 4'h0,
    ST_INT_RESET = 4'h1,
    ST_STANDBY = 4'h3,
    ST_WAKE_BIAS = 4'h2,
    ST_PWR_UP = 4'h6,
    ST_HOLD_CHECK = 4'h7,
    ST_HW_ON = 4'h5,
    ST_PWR_DOWN = 4'h4,
    ST_SW_ON = 4'hB
  } onoff_state_t;

endpackage

// >>> hold_glitch_filter.sv
`timescale 1ns/1ps
module hold_glitch_filter
#(
  parameter int GF_CYC = 12500
)
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic raw_in,
  output logic filt_out
);

  logic [15:0] cnt_r;

  // a new level must stand for the full filter time before it passes
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      cnt_r <= 16'h0000;
      filt_out <= 1'b0;
    end
    else if (raw_in == filt_out)
    begin
      cnt_r <= 16'h0000;
    end
    else if (cnt_r == 16'(GF_CYC - 1))
    begin
      cnt_r <= 16'h0000;
      filt_out <= raw_in;
    end
    else
    begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

endmodule

// >>> slot_sequencer.sv
`timescale 1ns/1ps
`include "onoff_cfg.svh"
module slot_sequencer
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic clear_in,
  input wire logic up_start_in,
  input wire logic down_start_in,
  output logic [2:0] slot_en_out,
  output logic up_done_out,
  output logic down_done_out
);

  logic active_r;
  logic dir_up_r;
  logic [15:0] tmr_r;
  logic tick;

  assign tick = active_r && (tmr_r == `ONOFF_SLOT_STEP_CYC - 16'h0001);

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      active_r <= 1'b0;
      dir_up_r <= 1'b0;
      tmr_r <= 16'h0000;
    end
    else if (clear_in)
    begin
      active_r <= 1'b0;
      tmr_r <= 16'h0000;
    end
    else if (up_start_in || down_start_in)
    begin
      active_r <= 1'b1;
      dir_up_r <= up_start_in;
      tmr_r <= 16'h0000;
    end
    else if (tick)
    begin
      tmr_r <= 16'h0000;
      if ((dir_up_r && slot_en_out[1]) || (!dir_up_r && slot_en_out == 3'h1))
      begin
        active_r <= 1'b0;
      end
    end
    else if (active_r)
    begin
      tmr_r <= tmr_r + 16'h0001;
    end
  end

  // slots come up 0,1,2 and go down 2,1,0
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      slot_en_out <= 3'h0;
      up_done_out <= 1'b0;
      down_done_out <= 1'b0;
    end
    else
    begin
      up_done_out <= !clear_in && tick && dir_up_r && slot_en_out[1];
      down_done_out <= !clear_in && tick && !dir_up_r && slot_en_out == 3'h1;
      if (clear_in)
      begin
        slot_en_out <= 3'h0;
      end
      else if (tick && dir_up_r)
      begin
        slot_en_out <= {slot_en_out[1:0], 1'b1};
      end
      else if (tick)
      begin
        slot_en_out <= {1'b0, slot_en_out[2:1]};
      end
    end
  end

endmodule

// >>> hold_host_model.sv
`timescale 1ns/1ps
module hold_host_model
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic want_in,
  input wire logic [7:0] delay_in,
  input wire logic glitch_in,
  output logic hold_out
);
  logic [7:0] cnt_r;
  logic hold_r;
  ////////////////////////////////////////////////////////////
  // host raises hold late
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      cnt_r <= 8'h00;
      hold_r <= 1'b0;
    end
    else if (!want_in)
    begin
      cnt_r <= 8'h00;
      hold_r <= 1'b0;
    end
    else if (cnt_r >= delay_in)
      hold_r <= 1'b1;
    else
      cnt_r <= cnt_r + 8'h01;
  end
  // short drop lets the bench probe the filter
  assign hold_out = hold_r & ~glitch_in;
endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import onoff_pkg::*;
  logic clk_in = 1'b0;
  logic arst_n = 1'b0;
  logic sup = 1'b0, settled = 1'b0, io_ok = 1'b1, bias_ok = 1'b0, key = 1'b0;
  logic otemp = 1'b0, mrst = 1'b0, wr_en = 1'b0, rd_en = 1'b0, want = 1'b0, glitch = 1'b0;
  logic hold, irst_n, bus_en, bias_en, low_pwr;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d;
  logic [2:0] reg_en;
  onoff_state_t state;
  int n_fail = 0, checks = 0, k, n;

  always #4 clk_in = ~clk_in;

  on_off_state_controller #(.HOLD_GF_CYC(8), .HOLD_WAIT_CYC(64)) on_off_state_controller_i
  (
    .clk_in(clk_in), .arst_n_in(arst_n), .supply_ok_in(sup), .config_settled_in(settled),
    .io_supply_valid_in(io_ok), .bias_ok_flag_in(bias_ok), .debounced_key_flag_in(key),
    .power_hold_input_in(hold), .overtemp_lockout_in(otemp), .manual_reset_in(mrst),
    .addr_in(addr), .wr_data_in(wdata), .wr_en_in(wr_en), .rd_en_in(rd_en), .rd_data_out(rdata),
    .internal_reset_n_out(irst_n), .bus_enable_out(bus_en), .main_bias_en_out(bias_en),
    .bias_low_power_out(low_pwr), .regulator_en_out(reg_en), .state_out(state)
  );

  hold_host_model hold_host_model_i
  (
    .clk_in(clk_in), .arst_n_in(arst_n), .want_in(want), .delay_in(8'h14),
    .glitch_in(glitch), .hold_out(hold)
  );

  ////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // bounded wait; running out ends the run
  task automatic wait_st(input onoff_state_t s, input int lim);
    int i;
    for (i = 0; i < lim && state !== s; i++)
    begin
      @(posedge clk_in);
      #1;
    end
    chk({4'h0, state}, {4'h0, s});
    if (state !== s)
      report_and_stop();
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_in);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk_in);
    wr_en <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_in);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_in);
    rd_en <= 1'b0;
    #1;
    v = rdata;
  endtask

  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge clk_in);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
    chk({4'h0, state}, 8'h00);
    @(posedge clk_in);
    sup <= 1'b1;
    wait_st(ST_INT_RESET, 5);
    chk({7'h00, irst_n}, 8'h00);
    @(posedge clk_in);
    settled <= 1'b1;
    wait_st(ST_STANDBY, 10);
    chk({6'h00, bias_en, bus_en}, 8'h01);
    chk({5'h00, reg_en}, 8'h00);
    // bus goes quiet while its io supply is gone
    @(posedge clk_in);
    io_ok <= 1'b0;
    @(posedge clk_in);
    io_ok <= 1'b1;
    #1;
    chk({7'h00, bus_en}, 8'h00);
    // software path
    wr(8'h00, 8'h01);
    wait_st(ST_SW_ON, 3);
    chk({7'h00, bias_en}, 8'h01);
    rd(8'h00, d);
    chk(d, 8'h01);
    // outputs are registered, so they show a write one cycle later
    wr(8'h04, 8'h05);
    @(posedge clk_in);
    #1;
    chk({5'h00, reg_en}, 8'h05);
    rd(8'h0C, d);
    chk(d, 8'h00);
    wr(8'h04, 8'h00);
    @(posedge clk_in);
    #1;
    chk({5'h00, reg_en}, 8'h00);
    wr(8'h00, 8'h00);
    wait_st(ST_STANDBY, 3);
    chk({7'h00, bias_en}, 8'h00);
    rd(8'h08, d);
    chk(d, 8'h03);
    // key wake, bias late, host never holds
    @(posedge clk_in);
    key <= 1'b1;
    @(posedge clk_in);
    key <= 1'b0;
    wait_st(ST_WAKE_BIAS, 5);
    repeat (20) @(posedge clk_in);
    #1;
    chk({4'h0, state}, {4'h0, ST_WAKE_BIAS});
    @(posedge clk_in);
    bias_ok <= 1'b1;
    wait_st(ST_HOLD_CHECK, 200);
    n = 0;
    while (state === ST_HOLD_CHECK && n < 200)
    begin
      @(posedge clk_in);
      #1;
      n++;
    end
    chk({7'h00, n >= 64 && n <= 68}, 8'h01);
    wait_st(ST_PWR_DOWN, 1);
    wait_st(ST_STANDBY, 200);
    // soft wake, host holds after a delay
    @(posedge clk_in);
    want <= 1'b1;
    wr(8'h00, 8'h02);
    wait_st(ST_HW_ON, 400);
    chk({4'h0, bias_en, low_pwr, reg_en[2:1]}, 8'h0F);
    chk({7'h00, reg_en[0]}, 8'h01);
    @(posedge clk_in);
    glitch <= 1'b1;
    repeat (4) @(posedge clk_in);
    glitch <= 1'b0;
    repeat (20) @(posedge clk_in);
    #1;
    chk({4'h0, state}, {4'h0, ST_HW_ON});
    // every power-down cause, then back on
    for (k = 0; k < 5; k++)
    begin
      wait_st(ST_HW_ON, 400);
      @(posedge clk_in);
      case (k)
        0: want <= 1'b0;
        1: otemp <= 1'b1;
        2: wr(8'h00, 8'h02);
        3: wr(8'h00, 8'h04);
        default: mrst <= 1'b1;
      endcase
      wait_st(ST_PWR_DOWN, 30);
      @(posedge clk_in);
      otemp <= 1'b0;
      mrst <= 1'b0;
      want <= 1'b1;
      // cold reset wakes again by itself
      if (k != 2)
      begin
        wait_st(ST_STANDBY, 200);
        wr(8'h00, 8'h02);
      end
    end
    wait_st(ST_HW_ON, 400);
    @(posedge clk_in);
    sup <= 1'b0;
    wait_st(ST_NO_POWER, 3);
    chk({6'h00, bias_en, irst_n}, 8'h00);
    report_and_stop();
  end
endmodule
